// *** src/tma_pkg.sv ***
// Package for the temperature sequencer and converter output stage.
// Assumes one master clock (sys_clk) drives the whole block.
// Notes on behaviour
// - Temperature request waits for next zero crossing.
// - On crossing, sensor replaces first-channel converter input.
// - Result written 24 master-clock cycles after start.
// - Enabled completion drives active-low interrupt low.
// - Result is signed 8-bit, zero near seventy degrees.
// - Modulator clock is master clock divided by four.
// - Decimator averages bitstream into 20-bit words.
// - Both converters share one identical code scaling.
// - Waveform words are signed 20-bit at up to clock/128.
// - Overrange saturates at 40000h and C0000h.
// - Nominal full scale swings D7AE1h to 2851Fh.
// - First-channel output gain adjustable by plus/minus half.
// - Status flags set regardless of enable mask.
package tma_pkg;

   // -------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------
   localparam int unsigned CLK_HZ         = 20_000_000;
   localparam int unsigned TEMP_CONV_CYC  = 24;
   localparam int unsigned MOD_CLK_DIV    = 4;
   localparam int unsigned DECIM_CYC      = 128;
   localparam int unsigned DECIM_SAMPLES  = DECIM_CYC / MOD_CLK_DIV;

   // -------------------------------------------------------------
   // Widths and codes
   // -------------------------------------------------------------
   localparam int unsigned WORD_W         = 20;
   localparam int unsigned SUM_W          = 7;
   localparam int unsigned GAIN_W         = 12;
   localparam int unsigned GAIN_FRAC      = 12;
   localparam int unsigned SCALE_SHIFT    = 13;
   localparam int unsigned TEMP_W         = 8;
   localparam int unsigned TACC_W         = 6;
   localparam logic signed [WORD_W:0] CODE_POS_LIMIT = 21'sh04_0000;
   localparam logic signed [WORD_W:0] CODE_NEG_LIMIT = -21'sh04_0000;
   localparam logic [WORD_W-1:0]      NOM_FS_POS     = 20'h2_851F;
   localparam logic [WORD_W-1:0]      NOM_FS_NEG     = 20'hD_7AE1;

   // -------------------------------------------------------------
   // Status and enable bit positions
   // -------------------------------------------------------------
   localparam int unsigned ST_OVERRUN     = 0;
   localparam int unsigned ST_WAVE_SAMPLE = 3;
   localparam int unsigned ST_TEMP_DONE   = 5;
   localparam int unsigned ST_W           = 8;
   localparam logic [ST_W-1:0] STATUS_RESET = 8'h00;

   // -------------------------------------------------------------
   // Types
   // -------------------------------------------------------------
   typedef enum logic [1:0] {
      TMA_T_IDLE    = 2'b00,
      TMA_T_PENDING = 2'b01,
      TMA_T_CONVERT = 2'b10
   } tma_temp_state_t;

   typedef struct packed {
      logic              chan;
      logic [WORD_W-1:0] code;
   } tma_wave_word_t;

   localparam int unsigned WAVE_W = $bits(tma_wave_word_t);

endpackage : tma_pkg

// *** src/tma_skid_buf.sv ***
// Two-entry buffer with valid/ready on both sides.
// Assumes producer and consumer share the same clock.
`timescale 1ns/100ps
module tma_skid_buf #(
   parameter int unsigned WIDTH = 21
) (
   // Clock and reset
   input  wire logic             sys_clk,
   input  wire logic             reset,
   // Filling side
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   // Draining side
   output logic [WIDTH-1:0]      out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);

   logic [WIDTH-1:0] skid_q;
   logic             skid_v_q;
   wire              out_free = !out_valid || out_ready;
   wire              push     = in_valid && in_ready;

   // Ready comes from a flop so the producer never sees a combinational path
   assign in_ready = !skid_v_q;

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         out_data  <= '0;
         out_valid <= 1'b0;
         skid_q    <= '0;
         skid_v_q  <= 1'b0;
      end else begin
         if (out_free) begin
            out_valid <= skid_v_q || push;
            out_data  <= skid_v_q ? skid_q : in_data;
            skid_v_q  <= skid_v_q && push;
            if (skid_v_q && push) begin
               skid_q <= in_data;
            end
         end else if (push) begin
            skid_q   <= in_data;
            skid_v_q <= 1'b1;
         end
      end
   end

endmodule : tma_skid_buf

// *** src/tma_temp_adc.sv ***
// Temperature sequencer and sigma-delta converter digital output stage.
// Assumes modulator bitstreams and zero-crossing arrive from the analog side
// asynchronously, and that mode/enable/gain inputs come from registers
// on sys_clk.
`timescale 1ns/100ps
module tma_temp_adc #(
   parameter logic signed [7:0] TEMP_SCALE  = 8'sh04,
   parameter logic signed [7:0] TEMP_OFFSET = 8'sh00
) (
   // Clock and reset
   input  wire logic                    sys_clk,
   input  wire logic                    reset,
   // Analog side
   input  wire logic                    mod_bit_ch1,
   input  wire logic                    mod_bit_ch2,
   input  wire logic                    zero_cross,
   output logic                         mod_clk,
   output logic                         temp_route_sel,
   // Control from mode and enable registers
   input  wire logic                    temp_request,
   input  wire logic [1:0]              wave_rate_sel,
   input  wire logic                    wave_src_sel,
   input  wire logic                    wave_enable,
   input  wire logic signed [11:0]      ch1_gain,
   input  wire logic [7:0]              interrupt_enable_mask,
   input  wire logic                    status_read_and_clear,
   // Results
   output logic [7:0]                   die_temperature_result,
   output logic [7:0]                   status,
   output logic                         irq_n,
   // Waveform stream
   output tma_pkg::tma_wave_word_t      wave_data,
   output logic                         wave_valid,
   input  wire logic                    wave_ready
);

   localparam int unsigned W  = tma_pkg::WORD_W;
   localparam int unsigned SW = tma_pkg::SUM_W;
   localparam int unsigned PW = W + 1 + tma_pkg::GAIN_W + 2;

   // -------------------------------------------------------------
   // Shared scaling and saturation
   // -------------------------------------------------------------
   // Both channels go through this so identical densities give identical codes while ch1_gain is zero
   function automatic logic signed [W:0] scale_sum(input logic signed [SW-1:0] s);
      logic signed [W:0] r;
      r = {{(W+1-SW){s[SW-1]}}, s} <<< tma_pkg::SCALE_SHIFT;
      return r;
   endfunction : scale_sum

   // Clamp instead of wrap on overrange
   function automatic logic [W-1:0] saturate(input logic signed [PW-1:0] v);
      logic [W-1:0] r;
      r = v[W-1:0];
      if (v > PW'(tma_pkg::CODE_POS_LIMIT)) begin
         r = tma_pkg::CODE_POS_LIMIT[W-1:0];
      end else if (v < PW'(tma_pkg::CODE_NEG_LIMIT)) begin
         r = tma_pkg::CODE_NEG_LIMIT[W-1:0];
      end
      return r;
   endfunction : saturate

   // -------------------------------------------------------------
   // Input synchronisers
   // -------------------------------------------------------------
   logic [2:0] sync1_q;
   logic [2:0] sync2_q;
   logic       zx_prev_q;
   wire        ch1_bit = sync2_q[0];
   wire        ch2_bit = sync2_q[1];
   wire        zx_rise = sync2_q[2] && !zx_prev_q;

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         sync1_q   <= 3'h0;
         sync2_q   <= 3'h0;
         zx_prev_q <= 1'b0;
      end else begin
         sync1_q   <= {zero_cross, mod_bit_ch2, mod_bit_ch1};
         sync2_q   <= sync1_q;
         zx_prev_q <= sync2_q[2];
      end
   end

   // -------------------------------------------------------------
   // Modulator clock and decimation timing
   // -------------------------------------------------------------
   logic [1:0] div_q;
   logic [4:0] dec_cnt_q;
   wire        mod_tick = (div_q == 2'(tma_pkg::MOD_CLK_DIV - 1));
   wire        dec_last = mod_tick && (dec_cnt_q == 5'(tma_pkg::DECIM_SAMPLES - 1));

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         div_q     <= 2'h0;
         mod_clk   <= 1'b0;
         dec_cnt_q <= 5'h0_0;
      end else begin
         div_q   <= div_q + 2'h1;
         mod_clk <= (div_q >= 2'(tma_pkg::MOD_CLK_DIV / 2 - 1)) && !mod_tick;
         if (mod_tick) begin
            dec_cnt_q <= dec_last ? 5'h0_0 : dec_cnt_q + 5'h0_1;
         end
      end
   end

   // -------------------------------------------------------------
   // Decimating averager, one per channel
   // -------------------------------------------------------------
   logic signed [SW-1:0] acc1_q;
   logic signed [SW-1:0] acc2_q;
   logic [W-1:0]         code1_q;
   logic [W-1:0]         code2_q;
   logic                 code_new_q;

   wire signed [SW-1:0] step1 = ch1_bit ? 7'sh01 : -7'sh01;
   wire signed [SW-1:0] step2 = ch2_bit ? 7'sh01 : -7'sh01;
   wire signed [SW-1:0] sum1  = acc1_q + step1;
   wire signed [SW-1:0] sum2  = acc2_q + step2;
   // Gain factor 1 + g/4096 spans roughly 0.5 to 1.5
   wire signed [tma_pkg::GAIN_W+1:0] gain_fac =
      14'sh1000 + {{2{ch1_gain[11]}}, ch1_gain};
   wire signed [PW-1:0] prod1 = scale_sum(sum1) * gain_fac;
   wire signed [PW-1:0] gained1 = prod1 >>> tma_pkg::GAIN_FRAC;
   wire signed [PW-1:0] plain2 = PW'(scale_sum(sum2));

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         acc1_q     <= 7'sh00;
         acc2_q     <= 7'sh00;
         code1_q    <= 20'h0_0000;
         code2_q    <= 20'h0_0000;
         code_new_q <= 1'b0;
      end else begin
         code_new_q <= dec_last;
         if (mod_tick) begin
            acc1_q <= dec_last ? 7'sh00 : sum1;
            acc2_q <= dec_last ? 7'sh00 : sum2;
         end
         if (dec_last) begin
            code1_q <= saturate(gained1);
            code2_q <= saturate(plain2);
         end
      end
   end

   // -------------------------------------------------------------
   // Waveform rate selection and stream
   // -------------------------------------------------------------
   logic [2:0]              rate_cnt_q;
   logic                    hold_v_q;
   tma_pkg::tma_wave_word_t hold_q;
   logic                    buf_ready;
   wire [2:0] rate_max  = 3'((4'h1 << wave_rate_sel) - 4'h1);
   wire       rate_hit  = code_new_q && wave_enable && (rate_cnt_q >= rate_max);
   wire       hold_take = hold_v_q && buf_ready;
   wire       overrun   = rate_hit && hold_v_q && !buf_ready;

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         rate_cnt_q <= 3'h0;
         hold_v_q   <= 1'b0;
         hold_q     <= '0;
      end else begin
         if (code_new_q) begin
            rate_cnt_q <= rate_hit ? 3'h0 : rate_cnt_q + 3'h1;
         end
         // A stalled word is kept; the newer one is dropped and flagged
         if (rate_hit && !(hold_v_q && !buf_ready)) begin
            hold_q   <= '{chan: wave_src_sel, code: wave_src_sel ? code2_q : code1_q};
            hold_v_q <= 1'b1;
         end else if (hold_take) begin
            hold_v_q <= 1'b0;
         end
      end
   end

   tma_skid_buf #(
      .WIDTH (tma_pkg::WAVE_W)
   ) u_buf (
      .sys_clk   (sys_clk),
      .reset     (reset),
      .in_data   (hold_q),
      .in_valid  (hold_v_q),
      .in_ready  (buf_ready),
      .out_data  (wave_data),
      .out_valid (wave_valid),
      .out_ready (wave_ready)
   );

   // -------------------------------------------------------------
   // Temperature sequencer
   // -------------------------------------------------------------
   tma_pkg::tma_temp_state_t t_state_q;
   logic [4:0]               t_cnt_q;
   logic signed [tma_pkg::TACC_W-1:0] t_acc_q;
   logic                     temp_done;
   wire signed [tma_pkg::TACC_W-1:0] t_step = ch1_bit ? 6'sh01 : -6'sh01;
   wire signed [tma_pkg::TACC_W-1:0] t_sum  = t_acc_q + t_step;
   wire signed [15:0] t_prod = t_sum * TEMP_SCALE;
   // Zero code sits near seventy degrees; offset trims the uncalibrated sensor
   wire [7:0] t_code = 8'(t_prod) - TEMP_OFFSET;
   wire       t_last = (t_cnt_q == 5'(tma_pkg::TEMP_CONV_CYC - 1));

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         t_state_q              <= tma_pkg::TMA_T_IDLE;
         t_cnt_q                <= 5'h0_0;
         t_acc_q                <= 6'sh00;
         temp_route_sel         <= 1'b0;
         die_temperature_result <= 8'h00;
         temp_done              <= 1'b0;
      end else begin
         temp_done <= 1'b0;
         case (t_state_q)
            tma_pkg::TMA_T_IDLE: begin
               if (temp_request) begin
                  t_state_q <= tma_pkg::TMA_T_PENDING;
               end
            end
            tma_pkg::TMA_T_PENDING: begin
               if (zx_rise) begin
                  t_state_q      <= tma_pkg::TMA_T_CONVERT;
                  temp_route_sel <= 1'b1;
                  t_cnt_q        <= 5'h0_0;
                  t_acc_q        <= 6'sh00;
               end
            end
            tma_pkg::TMA_T_CONVERT: begin
               t_cnt_q <= t_cnt_q + 5'h0_1;
               t_acc_q <= t_sum;
               if (t_last) begin
                  t_state_q              <= tma_pkg::TMA_T_IDLE;
                  temp_route_sel         <= 1'b0;
                  die_temperature_result <= t_code;
                  temp_done              <= 1'b1;
               end
            end
            default: begin
               t_state_q      <= tma_pkg::TMA_T_IDLE;
               temp_route_sel <= 1'b0;
            end
         endcase
      end
   end

   // -------------------------------------------------------------
   // Status flags and interrupt
   // -------------------------------------------------------------
   logic [7:0] st_set;
   always_comb begin
      st_set = 8'h00;
      st_set[tma_pkg::ST_TEMP_DONE]   = temp_done;
      st_set[tma_pkg::ST_WAVE_SAMPLE] = rate_hit;
      st_set[tma_pkg::ST_OVERRUN]     = overrun;
   end
   // New events win over a simultaneous read-and-clear
   wire [7:0] status_d = (status_read_and_clear ? 8'h00 : status) | st_set;

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         status <= tma_pkg::STATUS_RESET;
         irq_n  <= 1'b1;
      end else begin
         status <= status_d;
         irq_n  <= ~|(status_d & interrupt_enable_mask);
      end
   end

endmodule : tma_temp_adc

// *** dv/tma_temp_adc_sva.sv ***
// Checker: assertions on the ports of tma_temp_adc.
// Assumes one clock, sys_clk, and an async active-high reset.
`timescale 1ns/100ps
module tma_temp_adc_chk (
   // Clock and reset
   input wire logic                    sys_clk,
   input wire logic                    reset,
   // Observed ports
   input wire logic                    zero_cross,
   input wire logic                    mod_clk,
   input wire logic                    temp_route_sel,
   input wire logic [7:0]              interrupt_enable_mask,
   input wire logic [7:0]              die_temperature_result,
   input wire logic [7:0]              status,
   input wire logic                    irq_n,
   input wire tma_pkg::tma_wave_word_t wave_data,
   input wire logic                    wave_valid,
   input wire logic                    wave_ready
);
   default clocking dc @(posedge sys_clk); endclocking
   default disable iff (reset);

   // --------------------------------------------
   // Length of each sensor routing window
   // --------------------------------------------
   logic [5:0] route_cnt_q;
   logic [5:0] route_cnt_d;
   assign route_cnt_d = temp_route_sel ? route_cnt_q + 6'h01 : 6'h00;
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) route_cnt_q <= 6'h00;
      else route_cnt_q <= route_cnt_d;
   end

   // --------------------------------------------
   // Properties
   // --------------------------------------------
   mod_clk_div_a: assert property ($rose(mod_clk) |->
      mod_clk ##1 mod_clk ##1 !mod_clk ##1 !mod_clk ##1 mod_clk) else $error("mod_clk not /4");
   route_after_zx_a: assert property ($rose(temp_route_sel) |-> $past(zero_cross, 2))
      else $error("route rose without a crossing");
   conv_length_a: assert property ($fell(temp_route_sel) |-> route_cnt_q == 6'h18)
      else $error("conversion not 24 cycles");
   result_hold_a: assert property ($changed(die_temperature_result) |->
      $fell(temp_route_sel)) else $error("result changed outside conversion end");
   done_flag_a: assert property ($fell(temp_route_sel) |=> status[5])
      else $error("temperature flag not set");
   temp_irq_a: assert property ($rose(status[5]) && interrupt_enable_mask[5] |->
      ##[0:1] !irq_n) else $error("enabled completion gave no interrupt");
   code_clamp_a: assert property (wave_valid |-> ($signed(wave_data.code) <= 20'sh4_0000
      && $signed(wave_data.code) >= -20'sh4_0000)) else $error("code beyond clamp");
   stall_hold_a: assert property (wave_valid && !wave_ready |=>
      wave_valid && $stable(wave_data)) else $error("word lost under stall");
endmodule : tma_temp_adc_chk

// *** dv/tma_analog_model.sv ***
// Analog side stand-in: constant modulator levels and a crossing pulse.
// Assumes the bench asks for a crossing by raising zx_go for one cycle.
`timescale 1ns/100ps
module tma_analog_model (
   // Clock
   input  wire logic sys_clk,
   // Control from bench
   input  wire logic lvl_ch1,
   input  wire logic lvl_ch2,
   input  wire logic zx_go,
   // Analog side outputs
   output logic      mod_bit_ch1,
   output logic      mod_bit_ch2,
   output logic      zero_cross
);
   int zx_cnt = 0;
   // Full-scale input holds the bitstream at one level
   assign mod_bit_ch1 = lvl_ch1;
   assign mod_bit_ch2 = lvl_ch2;
   // Held high long enough to pass the synchroniser
   assign zero_cross  = (zx_cnt != 0);
   always @(posedge sys_clk) begin
      if (zx_go) zx_cnt <= 8;
      else if (zx_cnt != 0) zx_cnt <= zx_cnt - 1;
   end
endmodule : tma_analog_model

// *** dv/tb_top.sv ***
// Bench top: drives tma_temp_adc control inputs and checks its outputs.
// Assumes the analog stand-in model and one 20 MHz clock.
`timescale 1ns/100ps
module tb_top;
   typedef struct packed {
      logic [1:0] rate; logic src; logic l1; logic l2;
      logic [11:0] gain; logic chan; logic [19:0] code; logic [15:0] gap;
   } tma_tb_case_t;
   localparam tma_tb_case_t CASES [4] = '{
      '{2'h0, 1'b0, 1'b1, 1'b0, 12'h000, 1'b0, 20'h4_0000, 16'h0080},
      '{2'h0, 1'b0, 1'b1, 1'b0, 12'h800, 1'b0, 20'h2_0000, 16'h0080},
      '{2'h0, 1'b0, 1'b0, 1'b0, 12'h7FF, 1'b0, 20'hC_0000, 16'h0080},
      '{2'h3, 1'b1, 1'b0, 1'b1, 12'h000, 1'b1, 20'h4_0000, 16'h0400}};
   logic               sys_clk = 1'b0, reset = 1'b1;
   logic               lvl_ch1 = 1'b0, lvl_ch2 = 1'b0, zx_go = 1'b0;
   logic               temp_request = 1'b0, wave_src_sel = 1'b0, wave_enable = 1'b0;
   logic               status_read_and_clear = 1'b0, wave_ready = 1'b1;
   logic [1:0]         wave_rate_sel = 2'h0;
   logic signed [11:0] ch1_gain = 12'sh000;
   logic [7:0]         interrupt_enable_mask = 8'h00;
   logic               mod_bit_ch1, mod_bit_ch2, zero_cross, mod_clk, temp_route_sel;
   logic               irq_n, wave_valid;
   logic [7:0]         die_temperature_result, status;
   tma_pkg::tma_wave_word_t wave_data, w;
   time                t0, t1;
   int                 miscompares = 0, num_checks = 0, mod_rises = 0, n0;

   tma_analog_model tma_analog_model_inst (.sys_clk(sys_clk), .lvl_ch1(lvl_ch1),
      .lvl_ch2(lvl_ch2), .zx_go(zx_go), .mod_bit_ch1(mod_bit_ch1),
      .mod_bit_ch2(mod_bit_ch2), .zero_cross(zero_cross));
   tma_temp_adc tma_temp_adc_inst (.sys_clk(sys_clk), .reset(reset),
      .mod_bit_ch1(mod_bit_ch1), .mod_bit_ch2(mod_bit_ch2), .zero_cross(zero_cross),
      .mod_clk(mod_clk), .temp_route_sel(temp_route_sel), .temp_request(temp_request),
      .wave_rate_sel(wave_rate_sel), .wave_src_sel(wave_src_sel), .wave_enable(wave_enable),
      .ch1_gain(ch1_gain), .interrupt_enable_mask(interrupt_enable_mask),
      .status_read_and_clear(status_read_and_clear),
      .die_temperature_result(die_temperature_result), .status(status), .irq_n(irq_n),
      .wave_data(wave_data), .wave_valid(wave_valid), .wave_ready(wave_ready));

   initial forever #25 sys_clk = ~sys_clk;
   always @(posedge mod_clk) mod_rises++;

   // --------------------------------------------
   // Tasks
   // --------------------------------------------
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : step
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic conclude();
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : conclude
   task automatic read_clear();
      status_read_and_clear = 1'b1;
      step(1);
      status_read_and_clear = 1'b0;
      step(1);
   endtask : read_clear
   // Looks one step after each edge, so the word is read once it has settled
   task automatic get_word(output time t, output tma_pkg::tma_wave_word_t wd);
      int n = 0;
      do begin step(1); n++; end while (wave_valid !== 1'b1 && n < 3000);
      check(wave_valid, 1'b1);
      t = $time;
      wd = wave_data;
   endtask : get_word
   // Requests stay rare: each one takes over the first-channel converter input
   task automatic temp_conv(input logic lvl, input logic [7:0] mask, input logic [7:0] res,
                            input logic irq);
      int n = 0;
      lvl_ch1 = lvl;
      interrupt_enable_mask = mask;
      temp_request = 1'b1;
      step(1);
      temp_request = 1'b0;
      step(20);
      check(temp_route_sel, 1'b0);
      zx_go = 1'b1;
      step(1);
      zx_go = 1'b0;
      while (temp_route_sel !== 1'b1 && n < 20) begin step(1); n++; end
      check(temp_route_sel, 1'b1);
      n = 0;
      while (temp_route_sel === 1'b1 && n < 40) begin step(1); n++; end
      check(n, 24);
      check(die_temperature_result, res);
      step(2);
      check(status[5], 1'b1);
      check(irq_n, irq);
      read_clear();
      check({irq_n, status[5]}, 2'b10);
      step(50);
      check(die_temperature_result, res);
      $display("temperature test done");
   endtask : temp_conv

   // --------------------------------------------
   // Sequence
   // --------------------------------------------
   initial begin
      step(5);
      reset = 1'b0;
      check({status, irq_n}, 9'h001);
      n0 = mod_rises;
      step(400);
      check(mod_rises - n0, 100);
      temp_conv(1'b1, 8'h20, 8'h60, 1'b0);
      temp_conv(1'b0, 8'h00, 8'hA0, 1'b1);
      wave_enable = 1'b1;
      foreach (CASES[i]) begin
         wave_rate_sel = CASES[i].rate;
         wave_src_sel = CASES[i].src;
         lvl_ch1 = CASES[i].l1;
         lvl_ch2 = CASES[i].l2;
         ch1_gain = CASES[i].gain;
         repeat (4) get_word(t0, w);
         get_word(t1, w);
         check(32'((t1 - t0) / 50), CASES[i].gap);
         check(w.chan, CASES[i].chan);
         check(w.code, CASES[i].code);
      end
      check(status[3], 1'b1);
      $display("stream test done");
      // Fastest rate so the stalled path fills well inside the wait
      wave_rate_sel = 2'h0;
      wave_ready = 1'b0;
      step(1600);
      check({wave_valid, status[0]}, 2'b11);
      wave_ready = 1'b1;
      step(4);
      read_clear();
      check(status[0], 1'b0);
      $display("stall test done");
      conclude();
   end

   initial begin
      #(25000 * 50);
      miscompares++;
      $display("BAD t=%0t watchdog expired", $time);
      conclude();
   end
endmodule : tb_top

bind tma_temp_adc tma_temp_adc_chk tma_temp_adc_chk_inst (.sys_clk(sys_clk), .reset(reset),
   .zero_cross(zero_cross), .mod_clk(mod_clk), .temp_route_sel(temp_route_sel),
   .interrupt_enable_mask(interrupt_enable_mask),
   .die_temperature_result(die_temperature_result), .status(status), .irq_n(irq_n),
   .wave_data(wave_data), .wave_valid(wave_valid), .wave_ready(wave_ready));
